// file: include/mdi_params.svh
`ifndef MDI_PARAMS_SVH
`define MDI_PARAMS_SVH
// fixed upper part of the target address byte (write form)
`define MDI_ADDR_BASE 8'hC0
`define MDI_GENERAL_CALL 7'h00
// register subaddresses
`define MDI_SUB_DRIVE 8'h00
`define MDI_SUB_ERROR 8'h01
`define MDI_DRIVE_RESET 8'h00
`define MDI_ERROR_RESET 8'h00
// field positions of the drive setting register
`define MDI_DIR_FWD_BIT 0
`define MDI_DIR_REV_BIT 1
`define MDI_VCODE_LSB 2
`define MDI_VCODE_MSB 7
// field positions of the error status register
`define MDI_ERR_SUM_BIT 0
`define MDI_ERR_SHORT_BIT 1
`define MDI_ERR_LOWSUP_BIT 2
`define MDI_ERR_HEAT_BIT 3
`define MDI_ERR_CAP_BIT 4
`define MDI_ERR_CLEAR_BIT 7
// three-level strap encodings
`define MDI_STRAP_LOW 2'h0
`define MDI_STRAP_OPEN 2'h1
`define MDI_STRAP_HIGH 2'h2
// strap synchroniser depth before the address may latch
`define MDI_STRAP_WAIT 2'h2
// clock and timing
`define MDI_REF_CLK_HZ 50000000
`define MDI_POWERUP_US 60
`define MDI_POWERUP_CYC ((`MDI_POWERUP_US * (`MDI_REF_CLK_HZ / 1000000)))
`define MDI_CAP_MS 275
`define MDI_CAP_CYC ((`MDI_CAP_MS * (`MDI_REF_CLK_HZ / 1000)))
// master divider: terminal count; the bus clock half period is this plus one ref_clk cycles
`define MDI_HALF_DIV 8'h04
// master register offsets on APB
`define MDI_APB_CMD 12'h000
`define MDI_APB_STAT 12'h004
`define MDI_APB_RDATA 12'h008
`endif

// file: include/mdi_pkg.sv
package mdi_pkg;
    // target bus engine states, gray along the usual path
    typedef enum logic [2:0] {
        MDI_T_IDLE = 3'h0,
        MDI_T_ADDR = 3'h1,
        MDI_T_AACK = 3'h3,
        MDI_T_WRX = 3'h2,
        MDI_T_WACK = 3'h6,
        MDI_T_RTX = 3'h7,
        MDI_T_RACK = 3'h5,
        MDI_T_DONE = 3'h4
    } mdi_tstate_t;
    // master bit-level states
    typedef enum logic [2:0] {
        MDI_M_IDLE = 3'h0,
        MDI_M_START = 3'h1,
        MDI_M_BIT = 3'h3,
        MDI_M_ACK = 3'h2,
        MDI_M_STOP = 3'h6,
        MDI_M_END = 3'h7
    } mdi_mstate_t;
endpackage

// file: include/mdi_bus_if.sv
`timescale 1ns/1ns
// open-drain two-wire bus joining master and target
interface mdi_bus_if;
    logic scl_o;
    logic scl_oe;
    logic sda_m_o;
    logic sda_m_oe;
    logic sda_t_o;
    logic sda_t_oe;
    logic scl_i;
    logic sda_i;
    // wired-and with pull-ups
    assign scl_i = ~(scl_oe & ~scl_o);
    assign sda_i = ~(sda_m_oe & ~sda_m_o) & ~(sda_t_oe & ~sda_t_o);
    modport target (input scl_i, input sda_i, output sda_t_o, output sda_t_oe);
    modport master (input scl_i, input sda_i, output scl_o, output scl_oe,
        output sda_m_o, output sda_m_oe);
endinterface

// file: rtl/mdi_target.sv
// The two-wire bus interface to the registers was chosen for this implementation.
`timescale 1ns/1ns
`include "mdi_params.svh"
// Contract
// - target detects start: sda falls, scl high
// - master sends address byte, msb first
// - target acks matching address during ack pulse
// - straps sampled at power-up and again on a low-supply event
// - straps decode to code; address base+2*code
// - general call address never acknowledged
// - read returns register selected by pointer
// - target acks each received data byte
// - bytes act only when complete and acked
// - stop: sda rises, scl high, ends transfer
// - master waits power-up delay before start
// - drive setting resets zero, code and direction
// - error status resets zero, bit layout fixed
// - writing clear bit resets all error flags
// - summary flag set whenever any error present
// - current-cap flag on long current limit
// - heat, supply, short flags from their shutdowns
// - low-supply event may resample the straps
// - direction bits command coast/fwd/rev/brake
// - voltage code drives output voltage setting
// - persistent limit sets flags, error pin low
module mdi_target #(
    parameter int CAP_CYC = `MDI_CAP_CYC
) (
    input wire logic ref_clk,
    input wire logic rstn,
    mdi_bus_if.target bus,
    input wire logic [1:0] addr_strap_lo,
    input wire logic [1:0] addr_strap_hi,
    input wire logic limit_active,
    input wire logic heat_event,
    input wire logic low_supply_event,
    input wire logic short_event,
    output logic [1:0] bridge_out_hi,
    output logic bridge_enable,
    output logic [5:0] voltage_code,
    output logic error_pin_low,
    output logic [7:0] error_status
);
    typedef struct packed {
        logic [1:0] scl_s;
        logic [1:0] sda_s;
        logic scl_d;
        logic sda_d;
        logic [3:0] ev_m;
        logic [3:0] ev_s;
        logic [3:0] strap_m;
        logic [3:0] strap_q;
        logic [1:0] strap_wait;
        logic strap_done;
        logic [6:0] my_addr;
        mdi_pkg::mdi_tstate_t st;
        logic [2:0] bitn;
        logic armed;
        logic [7:0] shift;
        logic rd;
        logic have_ptr;
        logic [7:0] ptr;
        logic [7:0] drive_setting;
        logic [4:0] flags;
        logic [31:0] cap_cnt;
        logic sda_low;
        logic [1:0] bridge_out_hi;
        logic bridge_enable;
        logic [5:0] voltage_code;
        logic error_pin_low;
        logic [7:0] error_status;
    } mdi_tgt_t;

    mdi_tgt_t r;
    mdi_tgt_t next_r;
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;
    logic [3:0] code;
    logic [7:0] rd_data;
    logic [7:0] err_view;

    // strap decode into the four-bit code
    function automatic logic [3:0] mdi_code(input logic [1:0] hi, input logic [1:0] lo);
        logic [3:0] h;
        logic [3:0] l;
        h = (hi == `MDI_STRAP_HIGH) ? 4'h2 : (hi == `MDI_STRAP_OPEN) ? 4'h1 : 4'h0;
        l = (lo == `MDI_STRAP_HIGH) ? 4'h2 : (lo == `MDI_STRAP_OPEN) ? 4'h1 : 4'h0;
        return 4'((h * 4'h3) + l);
    endfunction

    // edges and bus conditions on the synchronised lines
    always_comb begin
        scl_rise = r.scl_s[1] & ~r.scl_d;
        scl_fall = ~r.scl_s[1] & r.scl_d;
        start_seen = r.scl_s[1] & r.scl_d & r.sda_d & ~r.sda_s[1];
        stop_seen = r.scl_s[1] & r.scl_d & ~r.sda_d & r.sda_s[1];
        code = mdi_code(r.strap_q[3:2], r.strap_q[1:0]);
        err_view = {3'h0, r.flags};
        rd_data = (r.ptr == `MDI_SUB_ERROR) ? err_view :
            (r.ptr == `MDI_SUB_DRIVE) ? r.drive_setting : 8'h00;
    end

    // next-state logic
    always_comb begin
        next_r = r;
        next_r.scl_s = {r.scl_s[0], bus.scl_i};
        next_r.sda_s = {r.sda_s[0], bus.sda_i};
        next_r.scl_d = r.scl_s[1];
        next_r.sda_d = r.sda_s[1];
        // two-flop synchronisers for event and strap pins
        next_r.ev_m = {heat_event, low_supply_event, short_event, limit_active};
        next_r.ev_s = r.ev_m;
        next_r.strap_m = {addr_strap_hi, addr_strap_lo};
        next_r.strap_q = r.strap_m;
        if (r.strap_wait != `MDI_STRAP_WAIT) next_r.strap_wait = r.strap_wait + 2'h1;
        // latch address once straps are through; a supply event resamples
        if ((!r.strap_done && r.strap_wait == `MDI_STRAP_WAIT) || r.ev_s[2]) begin
            next_r.strap_done = 1'b1;
            next_r.my_addr = 7'((`MDI_ADDR_BASE + {3'h0, code, 1'b0}) >> 1);
        end
        // error sources latch; set wins over clear
        if (r.ev_s[1]) next_r.flags[`MDI_ERR_SHORT_BIT] = 1'b1;
        if (r.ev_s[2]) next_r.flags[`MDI_ERR_LOWSUP_BIT] = 1'b1;
        if (r.ev_s[3]) next_r.flags[`MDI_ERR_HEAT_BIT] = 1'b1;
        // current limit persistence timer
        if (r.ev_s[0] && r.bridge_enable) begin
            if (r.cap_cnt >= 32'(CAP_CYC - 1)) next_r.flags[`MDI_ERR_CAP_BIT] = 1'b1;
            else next_r.cap_cnt = r.cap_cnt + 32'h1;
        end else begin
            next_r.cap_cnt = 32'h0;
        end
        // bus engine
        if (start_seen) begin
            next_r.st = mdi_pkg::MDI_T_ADDR;
            next_r.bitn = 3'h0;
            next_r.armed = 1'b0;
            next_r.have_ptr = 1'b0;
            next_r.sda_low = 1'b0;
        end else if (stop_seen) begin
            next_r.st = mdi_pkg::MDI_T_IDLE;
            next_r.sda_low = 1'b0;
        end else begin
            case (r.st)
                mdi_pkg::MDI_T_ADDR, mdi_pkg::MDI_T_WRX: begin
                    if (scl_rise) begin
                        next_r.shift = {r.shift[6:0], r.sda_s[1]};
                        next_r.armed = 1'b1;
                    end
                    // the fall that closes the start carries no bit
                    if (scl_fall && r.armed) begin
                        next_r.bitn = r.bitn + 3'h1;
                        if (r.bitn == 3'h7) begin
                            if (r.st == mdi_pkg::MDI_T_ADDR) begin
                                if (r.shift[7:1] == r.my_addr &&
                                    r.shift[7:1] != `MDI_GENERAL_CALL) begin
                                    next_r.st = mdi_pkg::MDI_T_AACK;
                                    next_r.rd = r.shift[0];
                                    next_r.sda_low = 1'b1;
                                end else begin
                                    next_r.st = mdi_pkg::MDI_T_DONE;
                                end
                            end else begin
                                next_r.st = mdi_pkg::MDI_T_WACK;
                                next_r.sda_low = 1'b1;
                            end
                        end
                    end
                end
                mdi_pkg::MDI_T_AACK: begin
                    if (scl_fall) begin
                        next_r.bitn = 3'h0;
                        if (r.rd) begin
                            next_r.st = mdi_pkg::MDI_T_RTX;
                            next_r.shift = rd_data;
                            next_r.sda_low = ~rd_data[7];
                        end else begin
                            next_r.st = mdi_pkg::MDI_T_WRX;
                            next_r.sda_low = 1'b0;
                        end
                    end
                end
                mdi_pkg::MDI_T_WACK: begin
                    // the byte acts at the end of its acknowledge
                    if (scl_fall) begin
                        next_r.sda_low = 1'b0;
                        next_r.st = mdi_pkg::MDI_T_WRX;
                        next_r.bitn = 3'h0;
                        if (!r.have_ptr) begin
                            next_r.ptr = r.shift;
                            next_r.have_ptr = 1'b1;
                        end else if (r.ptr == `MDI_SUB_DRIVE) begin
                            next_r.drive_setting = r.shift;
                        end else if (r.ptr == `MDI_SUB_ERROR &&
                            r.shift[`MDI_ERR_CLEAR_BIT]) begin
                            next_r.flags = 5'h0;
                            next_r.cap_cnt = 32'h0;
                        end
                    end
                end
                mdi_pkg::MDI_T_RTX: begin
                    if (scl_fall) begin
                        next_r.bitn = r.bitn + 3'h1;
                        next_r.shift = {r.shift[6:0], 1'b0};
                        if (r.bitn == 3'h7) begin
                            next_r.st = mdi_pkg::MDI_T_RACK;
                            next_r.sda_low = 1'b0;
                        end else begin
                            next_r.sda_low = ~r.shift[6];
                        end
                    end
                end
                mdi_pkg::MDI_T_RACK: begin
                    if (scl_rise) begin
                        next_r.st = r.sda_s[1] ? mdi_pkg::MDI_T_DONE : mdi_pkg::MDI_T_RACK;
                    end
                    if (scl_fall && r.st == mdi_pkg::MDI_T_RACK) begin
                        next_r.st = mdi_pkg::MDI_T_RTX;
                        next_r.bitn = 3'h0;
                        next_r.shift = rd_data;
                        next_r.sda_low = ~rd_data[7];
                    end
                end
                default: next_r.sda_low = 1'b0;
            endcase
        end
        // re-assert event sets so they win over a same-cycle clear
        if (r.ev_s[1]) next_r.flags[`MDI_ERR_SHORT_BIT] = 1'b1;
        if (r.ev_s[2]) next_r.flags[`MDI_ERR_LOWSUP_BIT] = 1'b1;
        if (r.ev_s[3]) next_r.flags[`MDI_ERR_HEAT_BIT] = 1'b1;
        if (r.ev_s[0] && r.bridge_enable && r.cap_cnt >= 32'(CAP_CYC - 1))
            next_r.flags[`MDI_ERR_CAP_BIT] = 1'b1;
        // coast or brake clears the current-cap fault
        if (next_r.drive_setting[1:0] == 2'h0 || next_r.drive_setting[1:0] == 2'h3)
            next_r.flags[`MDI_ERR_CAP_BIT] = 1'b0;
        next_r.flags[`MDI_ERR_SUM_BIT] = |next_r.flags[4:1];
        // bridge command and registered outputs
        next_r.bridge_enable = |next_r.drive_setting[1:0];
        next_r.bridge_out_hi = next_r.drive_setting[1:0];
        next_r.voltage_code = next_r.drive_setting[`MDI_VCODE_MSB:`MDI_VCODE_LSB];
        next_r.error_pin_low = next_r.flags[`MDI_ERR_SUM_BIT];
        next_r.error_status = {3'h0, next_r.flags};
    end

    // state register, zero at power-up except the bus line samples, which start high
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            r <= '0;
            r.scl_s <= 2'h3;
            r.sda_s <= 2'h3;
            r.scl_d <= 1'b1;
            r.sda_d <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    assign bus.sda_t_o = 1'b0;
    assign bus.sda_t_oe = r.sda_low;
    assign bridge_out_hi = r.bridge_out_hi;
    assign bridge_enable = r.bridge_enable;
    assign voltage_code = r.voltage_code;
    assign error_pin_low = r.error_pin_low;
    assign error_status = r.error_status;
endmodule

// file: rtl/mdi_master.sv
`timescale 1ns/1ns
`include "mdi_params.svh"
// two-wire master driven from APB registers
module mdi_master #(
    parameter int POWERUP_CYC = `MDI_POWERUP_CYC
) (
    input wire logic ref_clk,
    input wire logic rstn,
    mdi_bus_if.master bus,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    typedef struct packed {
        logic [1:0] scl_s;
        logic [1:0] sda_s;
        logic [15:0] pu_cnt;
        logic pu_done;
        logic [7:0] div;
        logic ph;
        mdi_pkg::mdi_mstate_t st;
        logic [1:0] nbytes;
        logic [1:0] idx;
        logic [23:0] tx;
        logic [7:0] shift;
        logic [2:0] bitn;
        logic rd;
        logic nack;
        logic busy;
        logic [7:0] rdata;
        logic scl_low;
        logic sda_low;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } mdi_mst_t;

    mdi_mst_t r;
    mdi_mst_t next_r;
    logic tick;
    logic wr_cmd;

    always_comb begin
        next_r = r;
        next_r.scl_s = {r.scl_s[0], bus.scl_i};
        next_r.sda_s = {r.sda_s[0], bus.sda_i};
        // power-up wait before the first start condition
        if (!r.pu_done) begin
            next_r.pu_cnt = r.pu_cnt + 16'h1;
            if (r.pu_cnt >= 16'(POWERUP_CYC - 1)) next_r.pu_done = 1'b1;
        end
        // divider makes the half-phase enable
        tick = (r.div == `MDI_HALF_DIV);
        next_r.div = tick ? 8'h00 : r.div + 8'h01;
        // APB slave, one wait-free access
        wr_cmd = psel & penable & pwrite & (paddr == `MDI_APB_CMD) & ~r.busy;
        next_r.pready = psel & ~penable;
        next_r.pslverr = psel & ~penable & paddr != `MDI_APB_CMD &&
            paddr != `MDI_APB_STAT && paddr != `MDI_APB_RDATA;
        next_r.prdata = 32'h0;
        if (psel && !penable && !pwrite) begin
            if (paddr == `MDI_APB_STAT) next_r.prdata = {30'h0, r.nack, r.busy};
            else if (paddr == `MDI_APB_RDATA) next_r.prdata = {24'h0, r.rdata};
        end
        // cmd word: [31:24] addr byte, [23:16] b1, [15:8] b2, [1:0] byte count
        if (wr_cmd) begin
            next_r.tx = pwdata[31:8];
            next_r.nbytes = pwdata[1:0];
            next_r.rd = pwdata[24];
            next_r.busy = 1'b1;
            next_r.nack = 1'b0;
            next_r.idx = 2'h0;
            next_r.st = mdi_pkg::MDI_M_START;
            next_r.ph = 1'b0;
        end else if (tick && r.pu_done) begin
            next_r.ph = ~r.ph;
            case (r.st)
                mdi_pkg::MDI_M_START: begin
                    // sda falls while scl high, then scl falls
                    if (!r.ph) begin
                        next_r.sda_low = 1'b1;
                    end else begin
                        next_r.scl_low = 1'b1;
                        next_r.shift = r.tx[23:16];
                        next_r.bitn = 3'h0;
                        next_r.st = mdi_pkg::MDI_M_BIT;
                    end
                end
                mdi_pkg::MDI_M_BIT: begin
                    if (!r.ph) begin
                        next_r.sda_low = (r.rd && r.idx != 2'h0) ? 1'b0 : ~r.shift[7];
                        next_r.scl_low = 1'b0;
                    end else begin
                        next_r.scl_low = 1'b1;
                        next_r.shift = {r.shift[6:0], r.sda_s[1]};
                        next_r.bitn = r.bitn + 3'h1;
                        if (r.bitn == 3'h7) next_r.st = mdi_pkg::MDI_M_ACK;
                    end
                end
                mdi_pkg::MDI_M_ACK: begin
                    if (!r.ph) begin
                        // master acks read bytes except the last
                        next_r.sda_low = r.rd && r.idx != 2'h0 && r.idx != r.nbytes;
                        next_r.scl_low = 1'b0;
                    end else begin
                        next_r.scl_low = 1'b1;
                        if (r.rd && r.idx != 2'h0) next_r.rdata = r.shift;
                        if ((!r.rd || r.idx == 2'h0) && r.sda_s[1]) begin
                            next_r.nack = 1'b1;
                            next_r.st = mdi_pkg::MDI_M_STOP;
                        end else if (r.idx == r.nbytes) begin
                            next_r.st = mdi_pkg::MDI_M_STOP;
                        end else begin
                            next_r.idx = r.idx + 2'h1;
                            next_r.tx = {r.tx[15:0], 8'h00};
                            next_r.shift = r.tx[15:8];
                            next_r.bitn = 3'h0;
                            next_r.st = mdi_pkg::MDI_M_BIT;
                        end
                    end
                end
                mdi_pkg::MDI_M_STOP: begin
                    if (!r.ph) begin
                        next_r.sda_low = 1'b1;
                    end else begin
                        next_r.scl_low = 1'b0;
                        next_r.st = mdi_pkg::MDI_M_END;
                    end
                end
                mdi_pkg::MDI_M_END: begin
                    next_r.sda_low = 1'b0;
                    next_r.busy = 1'b0;
                    next_r.st = mdi_pkg::MDI_M_IDLE;
                end
                default: next_r.st = mdi_pkg::MDI_M_IDLE;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            r <= '0;
            r.scl_s <= 2'h3;
            r.sda_s <= 2'h3;
        end else begin
            r <= next_r;
        end
    end

    assign bus.scl_o = 1'b0;
    assign bus.scl_oe = r.scl_low;
    assign bus.sda_m_o = 1'b0;
    assign bus.sda_m_oe = r.sda_low;
    assign prdata = r.prdata;
    assign pready = r.pready;
    assign pslverr = r.pslverr;
endmodule

// file: tb/mdi_link_chk.sv
`timescale 1ns/1ns
// watches the shared two-wire link between master and target
module mdi_link_chk (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic scl_oe,
    input wire logic sda_m_oe,
    input wire logic sda_t_oe
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    logic scl_q, sda_q, busy, first;
    logic [3:0] bitc;
    logic [7:0] sh;
    logic start_c, stop_c, rise_c;
    // start, stop and clock rise as seen on the resolved wires
    assign start_c = scl_i && scl_q && sda_q && !sda_i;
    assign stop_c = scl_i && scl_q && !sda_q && sda_i;
    assign rise_c = scl_i && !scl_q;
    // frame flag, bit count and the first byte of a frame
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            busy <= 1'b0;
            first <= 1'b0;
            bitc <= 4'h0;
            sh <= 8'h00;
        end else begin
            scl_q <= scl_i;
            sda_q <= sda_i;
            if (start_c) begin
                busy <= 1'b1;
                first <= 1'b1;
                bitc <= 4'h0;
            end else if (stop_c) begin
                busy <= 1'b0;
                bitc <= 4'h0;
            end else if (rise_c && bitc == 4'h8) begin
                bitc <= 4'h0;
                first <= 1'b0;
            end else if (rise_c) begin
                sh <= {sh[6:0], sda_i};
                bitc <= bitc + 4'h1;
            end
        end
    end
    tgt_edge_a: assert property ($changed(sda_t_oe) |-> !scl_i)
        else $error("target moved data while clock high");
    ack_stands_a: assert property (($rose(scl_i) && sda_t_oe) |-> sda_t_oe [*8])
        else $error("target released data during clock high");
    scl_high_a: assert property ($rose(scl_i) |-> scl_i [*5])
        else $error("clock high phase too short");
    scl_low_a: assert property ($fell(scl_i) |-> !scl_i [*5])
        else $error("clock low phase too short");
    no_fight_a: assert property ((sda_t_oe && sda_m_oe) |-> !scl_i)
        else $error("both ends drive data while clock high");
    in_frame_a: assert property (sda_t_oe |-> busy)
        else $error("target drove data outside a frame");
    addr_ack_a: assert property ((rise_c && first && bitc == 4'h8 && sda_t_oe)
        |-> (sh[7:1] >= 7'h60 && sh[7:1] <= 7'h68)) else $error("target acked a foreign address");
    start_go_a: assert property (start_c |-> ##[1:40] !scl_i)
        else $error("clock did not follow start");
    stop_idle_a: assert property (stop_c |=> !scl_oe [*4])
        else $error("clock pulled after stop");
endmodule

// file: tb/mdi_test.sv
`timescale 1ns/1ns
`include "mdi_params.svh"
// apb driven master talking to the target across the link
module mdi_test;
    logic ref_clk, rstn, psel, penable, pwrite, pready, pslverr, br_en, err_low;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [1:0] strap_lo, strap_hi, out_hi;
    logic [3:0] ev;
    logic [5:0] vcode;
    logic [7:0] err_st, exp_e;
    int mismatches, n_checks, k;
    mdi_bus_if mdi_bus_if_inst ();
    mdi_master #(.POWERUP_CYC(20)) mdi_master_inst (.ref_clk(ref_clk), .rstn(rstn),
        .bus(mdi_bus_if_inst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    mdi_target #(.CAP_CYC(200)) mdi_target_inst (.ref_clk(ref_clk), .rstn(rstn),
        .bus(mdi_bus_if_inst), .addr_strap_lo(strap_lo), .addr_strap_hi(strap_hi),
        .limit_active(ev[3]), .heat_event(ev[2]), .low_supply_event(ev[1]),
        .short_event(ev[0]), .bridge_out_hi(out_hi), .bridge_enable(br_en),
        .voltage_code(vcode), .error_pin_low(err_low), .error_status(err_st));
    mdi_link_chk mdi_link_chk_inst (.ref_clk(ref_clk), .rstn(rstn),
        .scl_i(mdi_bus_if_inst.scl_i), .sda_i(mdi_bus_if_inst.sda_i),
        .scl_oe(mdi_bus_if_inst.scl_oe), .sda_m_oe(mdi_bus_if_inst.sda_m_oe),
        .sda_t_oe(mdi_bus_if_inst.sda_t_oe));
    // compare and count
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // one apb transfer, held until pready
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge ref_clk);
            if (pready === 1'b1) break;
        end
        if (i == 50) begin
            mismatches++;
            finish_test();
        end
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // poll the master until the link is quiet
    task automatic idle();
        int i;
        for (i = 0; i < 3000; i++) begin
            apb(1'b0, `MDI_APB_STAT, 32'h0);
            if (rd[0] === 1'b0) break;
        end
        if (i == 3000) begin
            mismatches++;
            finish_test();
        end
    endtask
    // one link frame; leaves the status word in rd
    task automatic cmd(input logic [7:0] a, input logic [7:0] b1, input logic [7:0] b2,
        input logic [1:0] n);
        idle();
        apb(1'b1, `MDI_APB_CMD, {a, b1, b2, 6'h00, n});
        idle();
        apb(1'b0, `MDI_APB_STAT, 32'h0);
    endtask
    task automatic reset_dut();
        rstn <= 1'b0;
        repeat (6) @(posedge ref_clk);
        rstn <= 1'b1;
    endtask
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    // main sequence
    initial begin
        {rstn, psel, penable, pwrite, paddr, pwdata} = '0;
        {strap_lo, strap_hi, ev, mismatches, n_checks} = '0;
        reset_dut();
        @(posedge ref_clk);
        chk("drive reset", {out_hi, br_en, vcode}, 32'h0);
        chk("error reset", {err_low, err_st}, 32'h0);
        for (k = 0; k < 9; k++) begin
            strap_hi <= 2'(k / 3);
            strap_lo <= 2'(k % 3);
            reset_dut();
            cmd(`MDI_ADDR_BASE + 8'(2 * k), 8'h00, {6'(k + 1), 2'b01}, 2'd2);
            chk("ack", rd[1], 1'b0);
            chk("vcode", vcode, 6'(k + 1));
            cmd(`MDI_ADDR_BASE + 8'(2 * k + 1), 8'h00, 8'h00, 2'd1);
            apb(1'b0, `MDI_APB_RDATA, 32'h0);
            chk("readback", rd[7:0], {6'(k + 1), 2'b01});
        end
        $display("address test done");
        strap_hi <= `MDI_STRAP_LOW;
        strap_lo <= `MDI_STRAP_LOW;
        cmd(8'hD0, 8'h00, 8'h55, 2'd2);
        chk("latched", {rd[1], 2'b00, vcode}, 9'h015);
        strap_hi <= `MDI_STRAP_HIGH;
        strap_lo <= `MDI_STRAP_HIGH;
        for (k = 0; k < 2; k++) begin
            cmd(k == 0 ? 8'hC0 : 8'h00, 8'h00, 8'h00, 2'd2);
            chk("refused", {rd[1], 2'b00, vcode}, 9'h115);
        end
        for (k = 0; k < 4; k++) begin
            cmd(8'hD0, 8'h00, {6'h3F, 2'(k)}, 2'd2);
            chk("bridge", {br_en, out_hi, vcode}, {k != 0, 2'(k), 6'h3F});
        end
        $display("bridge test done");
        cmd(8'hD0, 8'h00, 8'h05, 2'd2);
        for (k = 0; k < 4; k++) begin
            exp_e = 8'h01 | (8'h02 << k);
            ev[k] <= 1'b1;
            repeat (250) @(posedge ref_clk);
            ev[k] <= 1'b0;
            repeat (4) @(posedge ref_clk);
            chk("flags", {err_low, err_st}, {1'b1, exp_e});
            cmd(8'hD0, 8'h01, 8'h60, 2'd2);
            cmd(8'hD1, 8'h00, 8'h00, 2'd1);
            apb(1'b0, `MDI_APB_RDATA, 32'h0);
            chk("error read", rd[7:0], exp_e);
            cmd(8'hD0, 8'h01, 8'h80, 2'd2);
            chk("cleared", {err_low, err_st}, 32'h0);
        end
        $display("error test done");
        finish_test();
    end
endmodule
